//--- common/dmacfg_pkg.sv
/*
  shared constants and types of the dma channel configuration block:
  register addresses, field positions, reset state and carrier structs.
  assumes an 8-bit special-register bus driven by the cpu on the core clock.
*/
package dmacfg_pkg;

  // channel count and widths
  localparam int DC_NCH = 7;
  localparam int DC_AW  = 12;
  localparam int DC_OW  = 10;

  // register addresses
  localparam logic [7:0] DC_ADDR_NCF  = 8'hC9;
  localparam logic [7:0] DC_ADDR_BAL  = 8'hCA;
  localparam logic [7:0] DC_ADDR_BAH  = 8'hCB;
  localparam logic [7:0] DC_ADDR_AOL  = 8'hCC;
  localparam logic [7:0] DC_ADDR_AOH  = 8'hCD;
  localparam logic [7:0] DC_ADDR_SZL  = 8'hCE;
  localparam logic [7:0] DC_ADDR_SZH  = 8'hCF;
  localparam logic [7:0] DC_ADDR_SEL  = 8'hD1;
  localparam logic [7:0] DC_ADDR_FULL = 8'hD3;
  localparam logic [7:0] DC_ADDR_MID  = 8'hD4;
  localparam logic [7:0] DC_ADDR_BUSY = 8'hD5;
  localparam logic [7:0] DC_ADDR_NMD  = 8'hD6;

  // field positions
  localparam int DC_CF_FULL_LENGTH_IRQ_ENABLE  = 7;
  localparam int DC_CF_MIDPOINT_IRQ_ENABLE = 6;
  localparam int DC_CF_STALL  = 5;
  localparam int DC_CF_ENDIAN = 4;
  localparam int DC_MD_WRAP   = 0;
  localparam logic [2:0] DC_SEL_INVALID = 3'h7;

  // transfer function codes
  localparam logic [3:0] DC_FN_ENC_IN  = 4'h0;
  localparam logic [3:0] DC_FN_ENC_OUT = 4'h1;
  localparam logic [3:0] DC_FN_CRC_IN  = 4'h2;
  localparam logic [3:0] DC_FN_SPI_TX  = 4'h3;
  localparam logic [3:0] DC_FN_SPI_RX  = 4'h4;
  localparam logic [3:0] DC_FN_KEY_IN  = 4'h5;
  localparam logic [3:0] DC_FN_BLK_IN  = 4'h6;
  localparam logic [3:0] DC_FN_XOR_IN  = 4'h7;
  localparam logic [3:0] DC_FN_AES_OUT = 4'h8;

  // peripheral targets
  typedef enum logic [2:0] {
    DC_P_ENC  = 3'b000,
    DC_P_CRC  = 3'b001,
    DC_P_SPI  = 3'b010,
    DC_P_KEY  = 3'b011,
    DC_P_BLK  = 3'b100,
    DC_P_XOR  = 3'b101,
    DC_P_COUT = 3'b110,
    DC_P_NONE = 3'b111
  } dc_transfer_function_select_type;

  // buffer occupancy
  typedef enum logic [1:0] {
    DCB_EMPTY = 2'b00,
    DCB_ONE   = 2'b01,
    DCB_TWO   = 2'b10
  } dc_bstate_type;

  typedef struct packed {
    logic          to_xram;
    dc_transfer_function_select_type transfer_function_select;
  } dc_func_type;

  // one byte-transfer request
  typedef struct packed {
    logic [2:0]       chan;
    dc_transfer_function_select_type    transfer_function_select;
    logic             to_xram;
    logic [1:0]       lane;
    logic [DC_AW-1:0] addr;
  } dc_xfer_type;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dc_sfr_type;

  // whole state of the channel block
  typedef struct packed {
    logic [2:0]                    sel;
    logic [DC_NCH-1:0][7:0]        ncf;
    logic [DC_NCH-1:0]             wrap;
    logic [DC_NCH-1:0][DC_AW-1:0]  base;
    logic [DC_NCH-1:0][DC_OW-1:0]  off;
    logic [DC_NCH-1:0][DC_OW-1:0]  size;
    logic [DC_NCH-1:0]             fl;
    logic [DC_NCH-1:0]             mi;
    logic [DC_NCH-1:0]             busy;
    logic [7:0]                    rdata;
  } dc_state_type;

  localparam dc_state_type DC_STATE_RST = '0;

endpackage

//--- hw/dmacfg_buf.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dmacfg_buf
  import dmacfg_pkg::*;
#(
  parameter int W = 21
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  typedef struct packed {
    dc_bstate_type     st;
    logic              wp;
    logic              rp;
    logic [1:0][W-1:0] mem;
  } dcb_state_type;

  dcb_state_type s_r;
  dcb_state_type s_nxt;
  logic          push;
  logic          pop;

  // handshakes
  assign o_in_ready  = (s_r.st != DCB_TWO);
  assign o_out_valid = (s_r.st != DCB_EMPTY);
  assign o_out_data  = s_r.mem[s_r.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and occupancy update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp          = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    case (s_r.st)
      DCB_EMPTY: begin
        if (push) s_nxt.st = DCB_ONE;
      end
      DCB_ONE: begin
        if (push && !pop) s_nxt.st = DCB_TWO;
        else if (pop && !push) s_nxt.st = DCB_EMPTY;
      end
      DCB_TWO: begin
        if (pop) s_nxt.st = DCB_ONE;
      end
      default: begin
        s_nxt.st = DCB_EMPTY;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) s_r <= '0;
    else s_r <= s_nxt;
  end

endmodule

//--- hw/dmacfg_top.sv
/*
  seven-channel byte dma configuration front end: channel selector,
  indirect per-channel registers, offset counter, flags and request issue.
  assumes the cpu register bus runs on I_CORE_CLK and issues one-cycle strobes.
*/
// What this block does
// - three-bit selector, codes 0..6 pick a channel, code 7 is invalid
// - mode and configuration reads and writes reach the selected channel copy
// - selector bits 7..3 read zero, writes to them ignored
// - offset runs 0..size-1; at the end the full flag is set
// - with wrap set, offset returns to zero at the end
// - configuration bit 7 gates the full-length interrupt
// - configuration bit 6 gates the mid-point interrupt
// - configuration bit 5 stalls the channel until software clears it
// - configuration bit 4 picks byte order for encoder transfers
// - configuration bits 3..0 pick one of nine transfer functions
// - codes 0..4 serve encoder, crc and spi transfers
// - codes 5..8 serve cipher key, block, xor and output
// - offset steps by one per byte, from the base address
// - mid flag at half size, or half plus one for odd sizes
// - full and mid flags stay until software clears or reset
// - writing busy 1 starts a channel; busy reads 1 while running
`timescale 1ns/1ps
module dmacfg_top
  import dmacfg_pkg::*;
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_B,
  // register bus
  input  wire dc_sfr_type  I_SFR,
  output logic [7:0]       O_SFR_RDATA,
  // transfer requests
  output dc_xfer_type      O_XFER_DATA,
  output logic             O_XFER_VALID,
  input  wire logic        I_XFER_READY,
  // interrupt requests
  output logic             O_FULL_IRQ,
  output logic             O_MID_IRQ
);

  dc_state_type         s_r;
  dc_state_type         s_nxt;
  logic                 sel_ok;
  logic [2:0]           sel_i;
  logic [DC_NCH-1:0]    run_m;
  logic [2:0]           act;
  logic                 any_run;
  logic                 buf_ready;
  logic                 push;
  logic                 last;
  logic                 at_mid;
  dc_func_type          fn;
  dc_xfer_type          req;
  logic [DC_NCH-1:0]    fset;
  logic [DC_NCH-1:0]    mset;

  // one bit of every channel configuration byte
  function automatic logic [DC_NCH-1:0] dc_col(input logic [DC_NCH-1:0][7:0] cf, input int pos);
    logic [DC_NCH-1:0] v;
    v = '0;
    for (int c = 0; c < DC_NCH; c++) v[c] = cf[c][pos];
    return v;
  endfunction

  // transfer function decode
  function automatic dc_func_type dc_decode(input logic [3:0] code);
    dc_func_type f;
    f = '{to_xram: 1'b0, transfer_function_select: DC_P_NONE};
    case (code)
      DC_FN_ENC_IN:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_ENC};
      DC_FN_ENC_OUT: f = '{to_xram: 1'b1, transfer_function_select: DC_P_ENC};
      DC_FN_CRC_IN:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_CRC};
      DC_FN_SPI_TX:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_SPI};
      DC_FN_SPI_RX:  f = '{to_xram: 1'b1, transfer_function_select: DC_P_SPI};
      DC_FN_KEY_IN:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_KEY};
      DC_FN_BLK_IN:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_BLK};
      DC_FN_XOR_IN:  f = '{to_xram: 1'b0, transfer_function_select: DC_P_XOR};
      DC_FN_AES_OUT: f = '{to_xram: 1'b1, transfer_function_select: DC_P_COUT};
      default:       f = '{to_xram: 1'b0, transfer_function_select: DC_P_NONE};
    endcase
    return f;
  endfunction

  // true for the nine defined function codes
  function automatic logic dc_fn_ok(input logic [3:0] code);
    dc_func_type f;
    f = dc_decode(code);
    return (f.transfer_function_select != DC_P_NONE);
  endfunction

  // selector validity and safe index
  assign sel_ok = (s_r.sel != DC_SEL_INVALID);
  assign sel_i  = sel_ok ? s_r.sel : 3'h0;

  // runnable channels: busy, not stalled, valid function
  always_comb begin
    run_m = '0;
    for (int c = 0; c < DC_NCH; c++) begin
      run_m[c] = s_r.busy[c] && !s_r.ncf[c][DC_CF_STALL]
                 && dc_fn_ok(s_r.ncf[c][3:0]);
    end
  end

  // lowest runnable channel wins
  always_comb begin
    act = 3'h0;
    for (int c = DC_NCH - 1; c >= 0; c--) begin
      if (run_m[c]) act = 3'(c);
    end
  end

  // request word for the active channel
  assign any_run = |run_m;
  assign fn      = dc_decode(s_r.ncf[act][3:0]);
  assign last    = (s_r.off[act] == DC_OW'(s_r.size[act] - 10'h001));
  assign at_mid  = (s_r.off[act] == DC_OW'((11'(s_r.size[act]) + 11'h001) >> 1));
  assign push    = any_run && buf_ready;

  always_comb begin
    req         = '0;
    req.chan    = act;
    req.transfer_function_select  = fn.transfer_function_select;
    req.to_xram = fn.to_xram;
    req.addr    = DC_AW'(s_r.base[act] + {2'h0, s_r.off[act]});
    // encoder words span three bytes; order follows the endian bit
    if (fn.transfer_function_select == DC_P_ENC) begin
      req.lane = 2'(s_r.off[act] % 10'h003);
      if (s_r.ncf[act][DC_CF_ENDIAN]) req.lane = 2'h2 - req.lane;
    end
  end

  // next state: engine, then register writes, then flags
  always_comb begin
    s_nxt = s_r;
    fset  = '0;
    mset  = '0;
    if (push) begin
      if (at_mid) mset[act] = 1'b1;
      if (last) begin
        fset[act] = 1'b1;
        if (s_r.wrap[act]) s_nxt.off[act] = '0;
        else s_nxt.busy[act] = 1'b0;
      end else begin
        s_nxt.off[act] = DC_OW'(s_r.off[act] + 10'h001);
      end
    end
    if (I_SFR.wr) begin
      case (I_SFR.addr)
        DC_ADDR_SEL:  s_nxt.sel = I_SFR.wdata[2:0];
        DC_ADDR_NCF:  if (sel_ok) s_nxt.ncf[sel_i] = I_SFR.wdata;
        DC_ADDR_NMD:  if (sel_ok) s_nxt.wrap[sel_i] = I_SFR.wdata[DC_MD_WRAP];
        DC_ADDR_BAL:  if (sel_ok) s_nxt.base[sel_i][7:0] = I_SFR.wdata;
        DC_ADDR_BAH:  if (sel_ok) s_nxt.base[sel_i][DC_AW-1:8] = I_SFR.wdata[3:0];
        DC_ADDR_AOL:  if (sel_ok) s_nxt.off[sel_i][7:0] = I_SFR.wdata;
        DC_ADDR_AOH:  if (sel_ok) s_nxt.off[sel_i][DC_OW-1:8] = I_SFR.wdata[1:0];
        DC_ADDR_SZL:  if (sel_ok) s_nxt.size[sel_i][7:0] = I_SFR.wdata;
        DC_ADDR_SZH:  if (sel_ok) s_nxt.size[sel_i][DC_OW-1:8] = I_SFR.wdata[1:0];
        DC_ADDR_BUSY: s_nxt.busy = s_nxt.busy | I_SFR.wdata[DC_NCH-1:0];
        default:      s_nxt.sel = s_nxt.sel;
      endcase
    end
    // sticky flags: software writes 0 to clear, a set in the same cycle wins
    s_nxt.fl = s_r.fl | fset;
    s_nxt.mi = s_r.mi | mset;
    if (I_SFR.wr && I_SFR.addr == DC_ADDR_FULL) s_nxt.fl = (s_r.fl & I_SFR.wdata[DC_NCH-1:0]) | fset;
    if (I_SFR.wr && I_SFR.addr == DC_ADDR_MID) s_nxt.mi = (s_r.mi & I_SFR.wdata[DC_NCH-1:0]) | mset;
    // read data, captured on the read strobe
    if (I_SFR.rd) begin
      case (I_SFR.addr)
        DC_ADDR_SEL:  s_nxt.rdata = {5'h00, s_r.sel};
        DC_ADDR_NCF:  s_nxt.rdata = sel_ok ? s_r.ncf[sel_i] : 8'h00;
        DC_ADDR_NMD:  s_nxt.rdata = sel_ok ? {7'h00, s_r.wrap[sel_i]} : 8'h00;
        DC_ADDR_BAL:  s_nxt.rdata = sel_ok ? s_r.base[sel_i][7:0] : 8'h00;
        DC_ADDR_BAH:  s_nxt.rdata = sel_ok ? {4'h0, s_r.base[sel_i][DC_AW-1:8]} : 8'h00;
        DC_ADDR_AOL:  s_nxt.rdata = sel_ok ? s_r.off[sel_i][7:0] : 8'h00;
        DC_ADDR_AOH:  s_nxt.rdata = sel_ok ? {6'h00, s_r.off[sel_i][DC_OW-1:8]} : 8'h00;
        DC_ADDR_SZL:  s_nxt.rdata = sel_ok ? s_r.size[sel_i][7:0] : 8'h00;
        DC_ADDR_SZH:  s_nxt.rdata = sel_ok ? {6'h00, s_r.size[sel_i][DC_OW-1:8]} : 8'h00;
        DC_ADDR_FULL: s_nxt.rdata = {1'b0, s_r.fl};
        DC_ADDR_MID:  s_nxt.rdata = {1'b0, s_r.mi};
        DC_ADDR_BUSY: s_nxt.rdata = {1'b0, s_r.busy};
        default:      s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) s_r <= DC_STATE_RST;
    else s_r <= s_nxt;
  end

  // outputs
  assign O_SFR_RDATA = s_r.rdata;
  assign O_FULL_IRQ  = |(s_r.fl & dc_col(s_r.ncf, DC_CF_FULL_LENGTH_IRQ_ENABLE));
  assign O_MID_IRQ   = |(s_r.mi & dc_col(s_r.ncf, DC_CF_MIDPOINT_IRQ_ENABLE));

  // request buffer toward the peripherals
  dmacfg_buf #(
    .W($bits(dc_xfer_type))
  ) u_buf (
    .i_clk       (I_CORE_CLK),
    .i_rst_b     (I_RST_B),
    .i_in_valid  (any_run),
    .o_in_ready  (buf_ready),
    .i_in_data   (req),
    .o_out_valid (O_XFER_VALID),
    .i_out_ready (I_XFER_READY),
    .o_out_data  (O_XFER_DATA)
  );

  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence sel_write_s;
    I_SFR.wr && I_SFR.addr == DC_ADDR_SEL;
  endsequence

  sequence sel_read_s;
    I_SFR.rd && I_SFR.addr == DC_ADDR_SEL;
  endsequence

  chk_sel_takes_code: assert property (sel_write_s |=> s_r.sel == $past(I_SFR.wdata[2:0]))
    else $error("selector did not take written code");
  chk_sel_upper_zero: assert property (sel_read_s |=> O_SFR_RDATA[7:3] == 5'h00)
    else $error("selector upper bits not zero");
  chk_ncf_indirect: assert property (I_SFR.wr && I_SFR.addr == DC_ADDR_NCF && sel_ok
      |=> s_r.ncf[$past(s_r.sel)] == $past(I_SFR.wdata))
    else $error("configuration write missed selected channel");
  chk_invalid_ignored: assert property (I_SFR.wr && I_SFR.addr == DC_ADDR_NCF && !sel_ok
      |=> s_r.ncf == $past(s_r.ncf))
    else $error("write with invalid selector changed configuration");
  chk_invalid_reads_zero: assert property (I_SFR.rd && I_SFR.addr == DC_ADDR_NCF && !sel_ok
      |=> O_SFR_RDATA == 8'h00)
    else $error("read with invalid selector not zero");
  chk_full_at_end: assert property (push && last |=> s_r.fl[$past(act)])
    else $error("full flag not set at end of transfer");
  chk_wrap_zero: assert property (push && last && s_r.wrap[act] |=> s_r.off[$past(act)] == '0)
    else $error("wrap did not reset offset");
  chk_end_idle: assert property (push && last && !s_r.wrap[act] |=> !s_r.busy[$past(act)])
    else $error("channel still busy after end");
  chk_offset_step: assert property (push && !last |=> s_r.off[$past(act)] == $past(s_r.off[act]) + 10'h001)
    else $error("offset did not step by one");
  chk_mid_flag: assert property (push && at_mid |=> s_r.mi[$past(act)])
    else $error("mid flag not set");
  chk_stall_blocks: assert property (sel_ok && s_r.busy[sel_i] && s_r.ncf[sel_i][DC_CF_STALL] && !I_SFR.wr
      |=> s_r.off[$past(sel_i)] == $past(s_r.off[sel_i]))
    else $error("stalled channel offset moved");
  chk_flag_sticky: assert property ($rose(s_r.fl[0]) && !(I_SFR.wr && I_SFR.addr == DC_ADDR_FULL)
      |=> s_r.fl[0])
    else $error("full flag dropped without software clear");
  chk_busy_start: assert property (I_SFR.wr && I_SFR.addr == DC_ADDR_BUSY && I_SFR.wdata[0] && !(push && act == 3'h0)
      |=> s_r.busy[0])
    else $error("busy write did not start channel");
  chk_full_irq: assert property (s_r.fl[3] && s_r.ncf[3][DC_CF_FULL_LENGTH_IRQ_ENABLE] |-> O_FULL_IRQ)
    else $error("enabled full flag raised no interrupt");
  chk_mid_irq: assert property (s_r.mi[3] && s_r.ncf[3][DC_CF_MIDPOINT_IRQ_ENABLE] |-> O_MID_IRQ)
    else $error("enabled mid flag raised no interrupt");
  chk_func_route: assert property (push && s_r.ncf[act][3:0] == DC_FN_AES_OUT
      |-> req.transfer_function_select == DC_P_COUT && req.to_xram)
    else $error("cipher output code routed wrongly");
  chk_func_spi_rx: assert property (push && s_r.ncf[act][3:0] == DC_FN_SPI_RX
      |-> req.transfer_function_select == DC_P_SPI && req.to_xram)
    else $error("spi receive code routed wrongly");

endmodule

//--- sim/dmacfg_sink.sv
/*
  far-side consumer of transfer words; keeps each word it takes.
  assumes the bench drives i_hold to stall it.
*/
`timescale 1ns/1ps
module dmacfg_sink
  import dmacfg_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // bench control
  input  wire logic        i_hold,
  // transfer link
  input  wire logic        i_valid,
  input  wire dc_xfer_type i_data,
  output logic             o_ready
);
  dc_xfer_type got[$];
  // ready unless the bench stalls us
  assign o_ready = !i_hold;
  // keep every word taken
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got.push_back(i_data);
    end
  end
endmodule

//--- sim/dmacfg_tb.sv
/*
  bench of the dma channel block: bus tasks and scenarios.
  assumes the sink model as the consumer of transfer words.
*/
`timescale 1ns/1ps
module tb
  import dmacfg_pkg::*;
;
  logic        clk;
  logic        rst_b;
  dc_sfr_type  sfr;
  logic [7:0]  rdata;
  dc_xfer_type xd;
  logic        xv;
  logic        xr;
  logic        full_irq;
  logic        mid_irq;
  logic        hold;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  dc_xfer_type w;

  dmacfg_top dmacfg_top_inst (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_SFR(sfr), .O_SFR_RDATA(rdata),
    .O_XFER_DATA(xd), .O_XFER_VALID(xv), .I_XFER_READY(xr),
    .O_FULL_IRQ(full_irq), .O_MID_IRQ(mid_irq));
  dmacfg_sink dmacfg_sink_inst (
    .i_clk(clk), .i_hold(hold), .i_valid(xv), .i_data(xd), .o_ready(xr));

  // compare and count
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle bus strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    #1 sfr = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1 sfr = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 sfr = '0;
    @(posedge clk);
    #1 check(nm, {24'h0, exp}, {24'h0, rdata});
  endtask

  task automatic wait_words(input int n);
    int i;
    i = 0;
    while (dmacfg_sink_inst.got.size() < n && i < 200) begin
      @(posedge clk);
      #1 i++;
    end
    check("word count", n, dmacfg_sink_inst.got.size());
  endtask

  task automatic setup(input logic [2:0] ch, input logic [7:0] cf, input logic [11:0] base, input logic [9:0] sz);
    wr(DC_ADDR_SEL, {5'h0, ch});
    wr(DC_ADDR_NCF, cf);
    wr(DC_ADDR_NMD, 8'h00);
    wr(DC_ADDR_BAL, base[7:0]);
    wr(DC_ADDR_BAH, {4'h0, base[11:8]});
    wr(DC_ADDR_AOL, 8'h00);
    wr(DC_ADDR_AOH, 8'h00);
    wr(DC_ADDR_SZL, sz[7:0]);
    wr(DC_ADDR_SZH, {6'h00, sz[9:8]});
    dmacfg_sink_inst.got.delete();
  endtask

  // selector, reset values and indirect copies
  task automatic t_regs();
    int c;
    rd(DC_ADDR_SEL, 8'h00, "sel reset");
    rd(DC_ADDR_NCF, 8'h00, "cfg reset");
    rd(DC_ADDR_NMD, 8'h00, "mode reset");
    wr(DC_ADDR_SEL, 8'hFE);
    rd(DC_ADDR_SEL, 8'h06, "sel upper");
    wr(8'h80, 8'h5A);
    rd(8'h80, 8'h00, "unmapped");
    for (c = 0; c < 7; c++) begin
      wr(DC_ADDR_SEL, c[7:0]);
      wr(DC_ADDR_NCF, 8'h90 + c[7:0]);
      wr(DC_ADDR_NMD, {7'h0, c[0]});
    end
    for (c = 0; c < 7; c++) begin
      wr(DC_ADDR_SEL, c[7:0]);
      rd(DC_ADDR_NCF, 8'h90 + c[7:0], "cfg copy");
      rd(DC_ADDR_NMD, {7'h0, c[0]}, "mode copy");
    end
    wr(DC_ADDR_SEL, 8'h07);
    wr(DC_ADDR_NCF, 8'h3F);
    rd(DC_ADDR_NCF, 8'h00, "cfg invalid sel");
    rd(DC_ADDR_SEL, 8'h07, "sel invalid");
    wr(DC_ADDR_SEL, 8'h00);
    rd(DC_ADDR_NCF, 8'h90, "cfg kept");
  endtask

  // stalled consumer, flags and interrupt gating
  task automatic t_flags();
    int k;
    hold = 1'h1;
    setup(3'h3, 8'hC2, 12'h2FE, 10'h004);
    wr(DC_ADDR_BUSY, 8'h08);
    repeat (10) @(posedge clk);
    #1 check("valid held", 1, xv);
    check("word held", 12'h2FE, xd.addr);
    rd(DC_ADDR_BUSY, 8'h08, "busy run");
    rd(DC_ADDR_MID, 8'h00, "mid early");
    hold = 1'h0;
    wait_words(4);
    for (k = 0; k < 4; k++) begin
      w = dmacfg_sink_inst.got[k];
      check("addr", 12'h2FE + k, w.addr);
      check("chan", 3, w.chan);
      check("transfer_function_select crc", DC_P_CRC, w.transfer_function_select);
    end
    rd(DC_ADDR_FULL, 8'h08, "full flag");
    rd(DC_ADDR_MID, 8'h08, "mid flag");
    rd(DC_ADDR_BUSY, 8'h00, "busy done");
    rd(DC_ADDR_AOL, 8'h03, "offset end");
    check("full irq on", 1, full_irq);
    check("mid irq on", 1, mid_irq);
    wr(DC_ADDR_NCF, 8'h42);
    rd(DC_ADDR_FULL, 8'h08, "full kept");
    check("full irq off", 0, full_irq);
    check("mid irq kept", 1, mid_irq);
    wr(DC_ADDR_NCF, 8'h02);
    rd(DC_ADDR_MID, 8'h08, "mid kept");
    check("mid irq off", 0, mid_irq);
    wr(DC_ADDR_FULL, 8'h00);
    wr(DC_ADDR_MID, 8'h00);
    rd(DC_ADDR_FULL, 8'h00, "full clear");
    rd(DC_ADDR_MID, 8'h00, "mid clear");
  endtask

  // wrap, then stall in mid-run and resume
  task automatic t_wrap();
    int n;
    setup(3'h5, 8'h03, 12'h040, 10'h002);
    wr(DC_ADDR_NMD, 8'h01);
    wr(DC_ADDR_BUSY, 8'h20);
    wait_words(6);
    for (n = 0; n < 6; n++) begin
      w = dmacfg_sink_inst.got[n];
      check("wrap addr", 12'h040 + n % 2, w.addr);
    end
    wr(DC_ADDR_NCF, 8'h23);
    repeat (4) @(posedge clk);
    #1 n = dmacfg_sink_inst.got.size();
    repeat (20) @(posedge clk);
    #1 check("stalled", n, dmacfg_sink_inst.got.size());
    rd(DC_ADDR_BUSY, 8'h20, "busy stalled");
    rd(DC_ADDR_NCF, 8'h23, "stall kept");
    wr(DC_ADDR_NMD, 8'h00);
    wr(DC_ADDR_NCF, 8'h03);
    repeat (10) @(posedge clk);
    #1 check("resumed", 1, dmacfg_sink_inst.got.size() > n);
    rd(DC_ADDR_BUSY, 8'h00, "busy end");
  endtask

  // encoder lanes in both byte orders
  task automatic t_endian();
    int e;
    int k;
    for (e = 0; e < 2; e++) begin
      setup(3'h1, {3'h0, e[0], 4'h0}, 12'h100, 10'h003);
      wr(DC_ADDR_BUSY, 8'h02);
      wait_words(3);
      for (k = 0; k < 3; k++) begin
        w = dmacfg_sink_inst.got[k];
        check("lane", e ? 2 - k : k, w.lane);
      end
    end
  endtask

  // every function code, then an unused one
  task automatic t_funcs();
    int f;
    dc_transfer_function_select_type pt[9] = '{DC_P_ENC, DC_P_ENC, DC_P_CRC, DC_P_SPI, DC_P_SPI,
                             DC_P_KEY, DC_P_BLK, DC_P_XOR, DC_P_COUT};
    logic [8:0] tx = 9'h112;
    for (f = 0; f < 9; f++) begin
      setup(3'h0, f[7:0], 12'h0A5, 10'h001);
      wr(DC_ADDR_BUSY, 8'h01);
      wait_words(1);
      w = dmacfg_sink_inst.got[0];
      check("func transfer_function_select", pt[f], w.transfer_function_select);
      check("func dir", tx[f], w.to_xram);
    end
    setup(3'h0, 8'h09, 12'h0A5, 10'h001);
    wr(DC_ADDR_BUSY, 8'h01);
    repeat (20) @(posedge clk);
    #1 check("bad func", 0, dmacfg_sink_inst.got.size());
    rd(DC_ADDR_BUSY, 8'h01, "bad func busy");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    rst_b = 1'h0;
    sfr = '0;
    hold = 1'h0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'h1;
    t_regs();
    t_flags();
    t_wrap();
    t_endian();
    t_funcs();
    finish_test();
  end
endmodule
